// >>> src/p2m_pkg.sv
// Overview of operation
// [RULE_01] Reset clears both configuration registers to zero, so every pin starts as an input.
// [RULE_02] Two 8-bit read/write configuration registers hold four 2-bit fields each.
// [RULE_03] High field 00 makes the pin a Schmitt input that also feeds uart receive and sio clock.
// [RULE_04] Field 01 in either register makes the pin a push-pull general purpose output.
// [RULE_05] High field 10 routes uart transmit, uart receive out, sio clock out or sio out.
// [RULE_06] High field 11 routes lcd segment 3 on pin 7 down to segment 0 on pin 4.
// [RULE_07] Low field 00 on pins 3, 1, 0 is an input feeding sio in, capture in or ext clock.
// [RULE_08] Low field 10 on pins 3, 1, 0 picks analog seven, pwm or timer b pulse; 11 is unused.
// [RULE_09] Pin 2 low field 00 is input, 01 output, 10 the analog channel four input.
// [RULE_10] Pin 2 low field 11 drives the timer d toggle or pulse output onto the pin.
// [RULE_11] The registers answer only to direct register addresses, never other forms.
// [RULE_12] Output mode drives the data register bit; reading the data register returns pins.
// [RULE_13] Bit pairs 7:6, 5:4, 3:2, 1:0 control pins 7..4 high and pins 3..0 low.
package p2m_pkg;

  localparam logic [7:0] P2M_DATA_ADDR    = 8'hf2;
  localparam logic [7:0] P2M_HIGH_ADDR    = 8'he6;
  localparam logic [7:0] P2M_LOW_ADDR     = 8'he7;
  localparam logic [7:0] P2M_CONFIG_RESET = 8'h00;
  localparam logic [7:0] P2M_DATA_RESET   = 8'h00;
  localparam logic [7:0] P2M_UNMAPPED     = 8'h00;

  localparam int P2M_PINS = 8;

  typedef enum logic [1:0] {
    P2M_MODE_INPUT  = 2'h0,
    P2M_MODE_OUTPUT = 2'h1,
    P2M_MODE_ALT_A  = 2'h2,
    P2M_MODE_ALT_B  = 2'h3
  } p2m_mode_t;

  // Field of a pin within its register, pins 0..3 low, 4..7 high
  function automatic p2m_mode_t p2m_field(input logic [7:0] cfg, input int slot);
    return p2m_mode_t'(cfg[slot*2 +: 2]);
  endfunction

endpackage

// >>> src/p2m_pin_cell.sv
module p2m_pin_cell (
  // Mode and sources
  input  wire p2m_pkg::p2m_mode_t mode,
  input  wire logic               data_bit,
  input  wire logic               alt_a_out,
  input  wire logic               alt_a_oe,
  input  wire logic               alt_b_out,
  input  wire logic               alt_b_oe,
  // Pin drive
  output logic                    pin_out,
  output logic                    pin_oe,
  output logic                    in_enable
);

  always_comb begin
    pin_out   = 1'b0;
    pin_oe    = 1'b0;
    in_enable = 1'b0;
    unique case (mode)
      p2m_pkg::P2M_MODE_INPUT: begin
        in_enable = 1'b1;
      end
      p2m_pkg::P2M_MODE_OUTPUT: begin
        pin_out = data_bit;
        pin_oe  = 1'b1;
      end
      p2m_pkg::P2M_MODE_ALT_A: begin
        pin_out = alt_a_out;
        pin_oe  = alt_a_oe;
      end
      p2m_pkg::P2M_MODE_ALT_B: begin
        pin_out = alt_b_out;
        pin_oe  = alt_b_oe;
      end
    endcase
  end

endmodule

// >>> src/p2m_port2_mux.sv
module p2m_port2_mux (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic       reg_direct,
  output logic      [7:0] reg_rdata,
  // Pins
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  // Serial peripherals
  input  wire logic       uart_transmit,
  input  wire logic       uart_receive_out,
  input  wire logic       uart_receive_oe,
  input  wire logic       sio_clock_out,
  input  wire logic       sio_clock_oe,
  input  wire logic       sio_out,
  output logic            uart_receive,
  output logic            sio_clock,
  output logic            sio_in,
  // Lcd
  input  wire logic [3:0] lcd_segment_outputs,
  // Analog
  output logic            analog_channel_seven,
  output logic            analog_channel_four,
  // Timers
  input  wire logic       pwm_out,
  input  wire logic       timer_b_pulse_out,
  input  wire logic       timer_d_toggle_out,
  input  wire logic       timer_d_pulse_out,
  input  wire logic       timer_d_pulse_sel,
  output logic            timer_capture_in,
  output logic            timer_ext_clock
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] high_q;
  logic [7:0] low_q;
  logic [7:0] data_q;
  logic [7:0] rdata_d;
  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [7:0] in_en;
  logic [7:0] alt_a_out;
  logic [7:0] alt_a_oe;
  logic [7:0] alt_b_out;
  logic [7:0] alt_b_oe;
  logic       hit_high;
  logic       hit_low;
  logic       hit_data;

  // Only direct register addressing may reach the port registers
  assign hit_high = reg_direct && (reg_addr == p2m_pkg::P2M_HIGH_ADDR); // RULE_11
  assign hit_low  = reg_direct && (reg_addr == p2m_pkg::P2M_LOW_ADDR);  // RULE_11
  assign hit_data = reg_direct && (reg_addr == p2m_pkg::P2M_DATA_ADDR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_q <= p2m_pkg::P2M_CONFIG_RESET; // RULE_01
    end else if (reg_write && hit_high) begin
      high_q <= reg_wdata; // RULE_02
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= p2m_pkg::P2M_CONFIG_RESET; // RULE_01
    end else if (reg_write && hit_low) begin
      low_q <= reg_wdata; // RULE_02
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= p2m_pkg::P2M_DATA_RESET;
    end else if (reg_write && hit_data) begin
      data_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data read returns pin states, not the latch
  always_comb begin
    rdata_d = p2m_pkg::P2M_UNMAPPED;
    if (hit_high) begin
      rdata_d = high_q;
    end else if (hit_low) begin
      rdata_d = low_q;
    end else if (hit_data) begin
      rdata_d = pin_in; // RULE_12
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= p2m_pkg::P2M_UNMAPPED;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= p2m_pkg::P2M_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternative sources per pin; code 11 on pins 3, 1, 0 leaves the pin floating
  always_comb begin
    alt_a_out = {uart_transmit, uart_receive_out, sio_clock_out, sio_out, // RULE_05
                 analog_zero(), 1'b0, pwm_out, timer_b_pulse_out};        // RULE_08
    alt_a_oe  = {1'b1, uart_receive_oe, sio_clock_oe, 1'b1,
                 1'b0, 1'b0, 1'b1, 1'b1};
    alt_b_out = {lcd_segment_outputs, 1'b0,                               // RULE_06
                 timer_d_pulse_sel ? timer_d_pulse_out : timer_d_toggle_out, // RULE_10
                 1'b0, 1'b0};
    alt_b_oe  = {4'hf, 1'b0, 1'b1, 1'b0, 1'b0};
  end

  function automatic logic analog_zero();
    return 1'b0;
  endfunction

  genvar g;
  for (g = 0; g < p2m_pkg::P2M_PINS; g++) begin : g_pin
    p2m_pin_cell u_cell (
      .mode      (p2m_pkg::p2m_field(g >= 4 ? high_q : low_q, g % 4)), // RULE_13
      .data_bit  (data_q[g]),                                           // RULE_04
      .alt_a_out (alt_a_out[g]),
      .alt_a_oe  (alt_a_oe[g]),
      .alt_b_out (alt_b_out[g]),
      .alt_b_oe  (alt_b_oe[g]),
      .pin_out   (drv_out[g]),
      .pin_oe    (drv_oe[g]),
      .in_enable (in_en[g])
    );
  end

  // Registered pin drive keeps the top outputs glitch free, at one cycle of lag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end else begin
      pin_out <= drv_out; // RULE_12
      pin_oe  <= drv_oe;  // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral inputs, gated to zero unless the pin is in input mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uart_receive     <= 1'b0;
      sio_clock        <= 1'b0;
      sio_in           <= 1'b0;
      timer_capture_in <= 1'b0;
      timer_ext_clock  <= 1'b0;
    end else begin
      uart_receive     <= in_en[6] & pin_in[6]; // RULE_03
      sio_clock        <= in_en[5] & pin_in[5]; // RULE_03
      sio_in           <= in_en[3] & pin_in[3]; // RULE_07
      timer_capture_in <= in_en[1] & pin_in[1]; // RULE_07
      timer_ext_clock  <= in_en[0] & pin_in[0]; // RULE_07
    end
  end

  // Analog taps follow the pin only when the analog function is chosen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      analog_channel_seven <= 1'b0;
      analog_channel_four  <= 1'b0;
    end else begin
      analog_channel_seven <= (p2m_pkg::p2m_field(low_q, 3) == p2m_pkg::P2M_MODE_ALT_A)
                              & pin_in[3]; // RULE_08
      analog_channel_four  <= (p2m_pkg::p2m_field(low_q, 2) == p2m_pkg::P2M_MODE_ALT_A)
                              & pin_in[2]; // RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset
  cfg_reset_a: assert property (@(posedge clock) // RULE_01
    $rose(rst_n)
    |-> high_q == p2m_pkg::P2M_CONFIG_RESET && low_q == p2m_pkg::P2M_CONFIG_RESET)
    else $error("config not cleared by reset");

  reset_pins_a: assert property (@(posedge clock) // RULE_01
    $rose(rst_n)
    |-> !(|pin_oe) && !uart_receive && !sio_clock && !sio_in)
    else $error("pins driven after reset");

  // Register access
  cfg_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    reg_write && hit_low
    |=> low_q == $past(reg_wdata))
    else $error("low config write lost");

  high_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    reg_write && hit_high
    |=> high_q == $past(reg_wdata))
    else $error("high config write lost");

  cfg_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    reg_read && hit_low
    |=> reg_rdata == $past(low_q))
    else $error("low config read wrong");

  rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    !reg_read
    |=> reg_rdata == p2m_pkg::P2M_UNMAPPED)
    else $error("read data outside read cycle");

  direct_only_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    reg_write && !reg_direct
    |=> $stable(high_q) && $stable(low_q))
    else $error("non-direct access changed config");

  direct_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    reg_read && !reg_direct
    |=> reg_rdata == p2m_pkg::P2M_UNMAPPED)
    else $error("non-direct read answered");

  data_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    reg_read && hit_data
    |=> reg_rdata == $past(pin_in))
    else $error("data read not pin state");

  // Pin modes, one cycle behind the configuration
  output_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
    p2m_pkg::p2m_field(low_q, 0) == p2m_pkg::P2M_MODE_OUTPUT
    |=> pin_oe[0] && pin_out[0] == $past(data_q[0]))
    else $error("output mode pin 0 wrong");

  field_map_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
    p2m_pkg::p2m_field(high_q, 0) == p2m_pkg::P2M_MODE_OUTPUT
    |=> pin_oe[4] && pin_out[4] == $past(data_q[4]))
    else $error("low pair of high register not on pin 4");

  input_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    p2m_pkg::p2m_field(high_q, 3) == p2m_pkg::P2M_MODE_INPUT
    |=> !pin_oe[7])
    else $error("input pin driven");

  uart_rx_in_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    p2m_pkg::p2m_field(high_q, 2) == p2m_pkg::P2M_MODE_INPUT
    |=> !pin_oe[6] && uart_receive == $past(pin_in[6]))
    else $error("uart receive not fed from pin 6");

  uart_tx_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
    p2m_pkg::p2m_field(high_q, 3) == p2m_pkg::P2M_MODE_ALT_A
    |=> pin_oe[7] && pin_out[7] == $past(uart_transmit))
    else $error("uart transmit not on pin 7");

  lcd_route_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    p2m_pkg::p2m_field(high_q, 3) == p2m_pkg::P2M_MODE_ALT_B
    |=> pin_out[7] == $past(lcd_segment_outputs[3]))
    else $error("segment 3 not on pin 7");

  lcd_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    p2m_pkg::p2m_field(high_q, 0) == p2m_pkg::P2M_MODE_ALT_B
    |=> pin_oe[4] && pin_out[4] == $past(lcd_segment_outputs[0]))
    else $error("segment 0 not on pin 4");

  capture_in_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    p2m_pkg::p2m_field(low_q, 1) != p2m_pkg::P2M_MODE_INPUT
    |=> !timer_capture_in)
    else $error("capture fed from non-input pin");

  sio_in_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    p2m_pkg::p2m_field(low_q, 3) == p2m_pkg::P2M_MODE_INPUT
    |=> !pin_oe[3] && sio_in == $past(pin_in[3]))
    else $error("serial input not fed from pin 3");

  pwm_route_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    p2m_pkg::p2m_field(low_q, 1) == p2m_pkg::P2M_MODE_ALT_A
    |=> pin_oe[1] && pin_out[1] == $past(pwm_out))
    else $error("pwm not on pin 1");

  analog_seven_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    p2m_pkg::p2m_field(low_q, 3) == p2m_pkg::P2M_MODE_ALT_A
    |=> !pin_oe[3] && analog_channel_seven == $past(pin_in[3]))
    else $error("analog seven not fed from pin 3");

  no_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    p2m_pkg::p2m_field(low_q, 0) == p2m_pkg::P2M_MODE_ALT_B
    |=> !pin_oe[0])
    else $error("unavailable code drives pin 0");

  analog_four_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    p2m_pkg::p2m_field(low_q, 2) == p2m_pkg::P2M_MODE_ALT_A
    |=> !pin_oe[2] && analog_channel_four == $past(pin_in[2]))
    else $error("analog four not fed from pin 2");

  analog_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    p2m_pkg::p2m_field(low_q, 2) != p2m_pkg::P2M_MODE_ALT_A
    |=> !analog_channel_four)
    else $error("analog four fed outside analog mode");

  timer_d_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    p2m_pkg::p2m_field(low_q, 2) == p2m_pkg::P2M_MODE_ALT_B && !timer_d_pulse_sel
    |=> pin_oe[2] && pin_out[2] == $past(timer_d_toggle_out))
    else $error("timer d toggle not on pin 2");

  pulse_sel_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    p2m_pkg::p2m_field(low_q, 2) == p2m_pkg::P2M_MODE_ALT_B && timer_d_pulse_sel
    |=> pin_oe[2] && pin_out[2] == $past(timer_d_pulse_out))
    else $error("timer d pulse not on pin 2");

  // Main scenarios
  write_high_c:  cover property (@(posedge clock) reg_write && hit_high);
  lcd_mode_c:    cover property (@(posedge clock) high_q == 8'hff);
  serial_mode_c: cover property (@(posedge clock) high_q == 8'haa);
  pwm_mode_c:    cover property (@(posedge clock)
    p2m_pkg::p2m_field(low_q, 1) == p2m_pkg::P2M_MODE_ALT_A);
  pulse_pick_c:  cover property (@(posedge clock)
    p2m_pkg::p2m_field(low_q, 2) == p2m_pkg::P2M_MODE_ALT_B && timer_d_pulse_sel);

endmodule

// >>> bench/p2m_far_model.sv
module p2m_far_model (
  // Pin side of the port
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in,
  // Which serial peripheral claims its two-way pin, bit 0 receive, bit 1 clock
  input  wire logic [1:0] serial_claim,
  // Peripheral enables for the two-way serial pins
  output logic            rx_oe,
  output logic            sck_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin reads back the port's own drive, else the board level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
  // The peripherals decide when their two-way pins are driven
  assign rx_oe  = serial_claim[0];
  assign sck_oe = serial_claim[1];
endmodule

// >>> bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rst_n, reg_write, reg_read, reg_direct, sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, ext_level, src;
  logic [3:0] lcd;
  logic [1:0] claim;
  logic       rx_oe, sck_oe, u_rx, sck, si, an7, an4, cap, eclk;
  int         mismatches, check_count, cycles;

  p2m_far_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in), .serial_claim(claim), .rx_oe(rx_oe), .sck_oe(sck_oe));
  p2m_port2_mux dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_direct(reg_direct), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .uart_transmit(src[0]), .uart_receive_out(src[1]),
    .uart_receive_oe(rx_oe), .sio_clock_out(src[2]), .sio_clock_oe(sck_oe),
    .sio_out(src[3]), .uart_receive(u_rx), .sio_clock(sck), .sio_in(si),
    .lcd_segment_outputs(lcd), .analog_channel_seven(an7), .analog_channel_four(an4),
    .pwm_out(src[4]), .timer_b_pulse_out(src[5]), .timer_d_toggle_out(src[6]),
    .timer_d_pulse_out(src[7]), .timer_d_pulse_sel(sel), .timer_capture_in(cap),
    .timer_ext_clock(eclk));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dir = 1'b1);
    @(posedge clock);
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_direct <= dir;
    reg_write  <= 1'b1;
    @(posedge clock);
    reg_write  <= 1'b0;
    reg_direct <= 1'b1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic dir = 1'b1);
    @(posedge clock);
    reg_addr   <= a;
    reg_direct <= dir;
    reg_read   <= 1'b1;
    @(posedge clock);
    reg_read   <= 1'b0;
    reg_direct <= 1'b1;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // Config lands one cycle after the write, pins one cycle later
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    rst_n = 1'b0; reg_write = 1'b0; reg_read = 1'b0; reg_direct = 1'b1; sel = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; ext_level = 8'h60; src = 8'h00; lcd = 4'h9;
    claim = 2'b11;
    mismatches = 0; check_count = 0; cycles = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'he6, v); chk(v, 8'h00);
    rd(8'he7, v); chk(v, 8'h00);
    settle();
    chk(pin_oe, 8'h00);
    chk({6'h0, u_rx, sck}, 8'h03);
    // Accesses with one idle cycle between strobes, then readback
    wr(8'he6, 8'hc9); wr(8'he7, 8'h36);
    rd(8'he6, v); chk(v, 8'hc9);
    rd(8'he7, v); chk(v, 8'h36);
    wr(8'hf2, 8'ha5); wr(8'he6, 8'h55); wr(8'he7, 8'h55);
    settle();
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'ha5);
    chk({6'h0, u_rx, sck}, 8'h00);
    rd(8'hf2, v); chk(v, 8'ha5);
    wr(8'he6, 8'h00, 1'b0);
    rd(8'he6, v); chk(v, 8'h55);
    rd(8'h10, v); chk(v, 8'h00);
    rd(8'he6, v, 1'b0); chk(v, 8'h00);
    // Serial alternatives, each pin moved both ways
    wr(8'he6, 8'haa); wr(8'he7, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      src   <= k ? 8'h0a : 8'h05;
      claim <= k ? 2'b01 : 2'b10;
      settle();
      chk(pin_oe, {1'b1, claim[0], claim[1], 1'b1, 4'h0});
      chk(pin_out, {src[0], src[1], src[2], src[3], 4'h0});
    end
    wr(8'he6, 8'hff);
    settle();
    chk(pin_out & pin_oe, 8'h90);
    wr(8'he6, 8'h00); wr(8'he7, 8'haa);
    src <= 8'h10; ext_level <= 8'h0c;
    settle();
    chk(pin_oe, 8'h03);
    chk(pin_out & 8'h03, 8'h02);
    chk({6'h0, an7, an4}, 8'h03);
    chk({5'h0, si, cap, eclk}, 8'h00);
    // Pin 2 timer output, with the other low pins as inputs
    wr(8'he7, 8'h30);
    src <= 8'h40; ext_level <= 8'h0b;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      sel <= k[0];
      settle();
      chk(pin_oe, 8'h04);
      chk(pin_out & 8'h04, k ? 8'h00 : 8'h04);
    end
    chk({5'h0, si, cap, eclk}, 8'h07);
    chk({6'h0, an7, an4}, 8'h00);
    // Code 11 on pins 3, 1 and 0 leaves them undriven
    wr(8'he7, 8'hff);
    settle();
    chk(pin_oe, 8'h04);
    stop_test();
  end
endmodule
